// ==== lcd3_top.v ====
// channel three divider pair: registers, sync, force and cascade
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "lcd3_regs.vh"

module lcd3_top (
    mclk,
    sys_rst,
    tree_clk,
    sync_n,
    div1_low_cnt,
    div1_high_cnt,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata_q,
    div1_out_q,
    ch_out_q,
    sync_held_q
);
    input  wire                    mclk;
    input  wire                    sys_rst;
    input  wire                    tree_clk;
    input  wire                    sync_n;
    input  wire [3:0]              div1_low_cnt;
    input  wire [3:0]              div1_high_cnt;
    input  wire [`LCD3_ADDR_W-1:0] reg_addr;
    input  wire [7:0]              reg_wdata;
    input  wire                    reg_wr;
    input  wire                    reg_rd;
    output reg  [7:0]              reg_rdata_q;
    output reg                     div1_out_q;
    output reg                     ch_out_q;
    output reg                     sync_held_q;

    // ======================================================================
    // register file
    // ======================================================================
    reg  [7:0] phase_q;
    reg  [7:0] counts2_q;
    reg  [7:0] ctrl_q;
    reg  [7:0] dcc_q;
    reg        sync_seen_q;

    // write decode; unmapped and read-only offsets drop the write
    always @(posedge mclk) begin
        if (sys_rst) begin
            phase_q   <= `LCD3_RST_PHASE;
            counts2_q <= `LCD3_RST_COUNTS2;
            ctrl_q    <= `LCD3_RST_CTRL;
            dcc_q     <= `LCD3_RST_DCC;
        end else if (reg_wr) begin
            case (reg_addr)
                `LCD3_OFS_PHASE: begin
                    phase_q <= reg_wdata;
                end
                `LCD3_OFS_COUNTS2: begin
                    counts2_q <= reg_wdata;
                end
                `LCD3_OFS_CTRL: begin
                    ctrl_q <= reg_wdata & `LCD3_CTRL_MASK;
                end
                `LCD3_OFS_DCC: begin
                    dcc_q <= reg_wdata & `LCD3_DCC_MASK;
                end
                default: begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    // ======================================================================
    // field extraction
    // ======================================================================
    wire [3:0] phase2;
    wire [3:0] phase1;
    wire [3:0] low2;
    wire [3:0] high2;
    wire       byp2;
    wire       byp1;
    wire       nosync;
    wire       force_lvl;
    wire       start2;
    wire       start1;
    wire       dcc_en;

    assign phase2    = phase_q[`LCD3_HI_NIB_MSB:`LCD3_HI_NIB_LSB];
    assign phase1    = phase_q[`LCD3_LO_NIB_MSB:`LCD3_LO_NIB_LSB];
    assign low2      = counts2_q[`LCD3_HI_NIB_MSB:`LCD3_HI_NIB_LSB];
    assign high2     = counts2_q[`LCD3_LO_NIB_MSB:`LCD3_LO_NIB_LSB];
    assign byp2      = ctrl_q[`LCD3_CTRL_BYP2];
    assign byp1      = ctrl_q[`LCD3_CTRL_BYP1];
    assign nosync    = ctrl_q[`LCD3_CTRL_NOSYNC];
    assign force_lvl = ctrl_q[`LCD3_CTRL_FORCE];
    assign start2    = ctrl_q[`LCD3_CTRL_START2];
    assign start1    = ctrl_q[`LCD3_CTRL_START1];
    // duty correction is on while the disable bit is clear
    assign dcc_en    = ~dcc_q[`LCD3_DCC_OFF_BIT];

    // ======================================================================
    // chip sync handling
    // ======================================================================
    wire sync_hold;
    wire forced;

    // sync only reaches the dividers when not ignored
    assign sync_hold = ~sync_n & ~nosync;
    // force only bites with sync-ignore set; force alone does nothing
    assign forced    = nosync;

    // live hold flag and sticky record of any honoured sync
    always @(posedge mclk) begin
        if (sys_rst) begin
            sync_held_q <= 1'b0;
            sync_seen_q <= 1'b0;
        end else begin
            sync_held_q <= sync_hold;
            // set wins over the clear by a status read
            if (sync_hold) begin
                sync_seen_q <= 1'b1;
            end else if (reg_rd && reg_addr == `LCD3_OFS_STATUS) begin
                sync_seen_q <= 1'b0;
            end
        end
    end

    // ======================================================================
    // cascaded sub-dividers
    // ======================================================================
    wire div1_out;
    wire div2_out;

    // first stage runs off the distribution tree clock
    lcd3_subdiv u_div1 (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .in_lvl     (tree_clk),
        .bypass     (byp1),
        .hold       (sync_hold),
        .start_high (start1),
        .phase      (phase1),
        .low_cnt    (div1_low_cnt),
        .high_cnt   (div1_high_cnt),
        .dcc_en     (dcc_en),
        .out_q      (div1_out)
    );

    // second stage is clocked by the first stage output
    lcd3_subdiv u_div2 (
        .mclk       (mclk),
        .sys_rst    (sys_rst),
        .in_lvl     (div1_out),
        .bypass     (byp2),
        .hold       (sync_hold),
        .start_high (start2),
        .phase      (phase2),
        .low_cnt    (low2),
        .high_cnt   (high2),
        .dcc_en     (dcc_en),
        .out_q      (div2_out)
    );

    // ======================================================================
    // output stage
    // ======================================================================
    // one flop after the mux keeps the pin glitch free on force changes
    always @(posedge mclk) begin
        if (sys_rst) begin
            ch_out_q   <= 1'b0;
            div1_out_q <= 1'b0;
        end else begin
            div1_out_q <= div1_out;
            if (forced) begin
                ch_out_q <= force_lvl;
            end else begin
                ch_out_q <= div2_out;
            end
        end
    end

    // ======================================================================
    // read path
    // ======================================================================
    reg [7:0] status;

    // status snapshot of the block's own state
    always @* begin
        status                      = 8'h00;
        status[`LCD3_ST_SYNC_HELD]  = sync_held_q;
        status[`LCD3_ST_FORCED]     = forced;
        status[`LCD3_ST_DIV1_OUT]   = div1_out;
        status[`LCD3_ST_DIV2_OUT]   = div2_out;
        status[`LCD3_ST_CH_OUT]     = ch_out_q;
        status[`LCD3_ST_SYNC_SEEN]  = sync_seen_q;
    end

    // read data stand for the cycle after the strobe only
    always @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `LCD3_OFS_PHASE: begin
                    reg_rdata_q <= phase_q;
                end
                `LCD3_OFS_COUNTS2: begin
                    reg_rdata_q <= counts2_q;
                end
                `LCD3_OFS_CTRL: begin
                    reg_rdata_q <= ctrl_q;
                end
                `LCD3_OFS_DCC: begin
                    reg_rdata_q <= dcc_q;
                end
                `LCD3_OFS_STATUS: begin
                    reg_rdata_q <= status;
                end
                default: begin
                    reg_rdata_q <= 8'h00;
                end
            endcase
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end

endmodule

// ==== lcd3_regs.vh ====
// register map, field positions and reset values of the channel three divider
`ifndef LCD3_REGS_VH
`define LCD3_REGS_VH

// ==========================================================================
// register offsets (byte addresses on the plain register port)
// ==========================================================================
`define LCD3_ADDR_W          9
`define LCD3_OFS_PHASE       9'h19f
`define LCD3_OFS_COUNTS2     9'h1a0
`define LCD3_OFS_CTRL        9'h1a1
`define LCD3_OFS_DCC         9'h1a2
`define LCD3_OFS_STATUS      9'h1a3

// ==========================================================================
// reset values
// ==========================================================================
`define LCD3_RST_PHASE       8'h00
`define LCD3_RST_COUNTS2     8'h00
`define LCD3_RST_CTRL        8'h00
`define LCD3_RST_DCC         8'h00
`define LCD3_RST_COUNTS1     8'h00

// ==========================================================================
// field positions
// ==========================================================================
// nibble fields shared by the phase and count registers
`define LCD3_HI_NIB_MSB      7
`define LCD3_HI_NIB_LSB      4
`define LCD3_LO_NIB_MSB      3
`define LCD3_LO_NIB_LSB      0

// control register bits
`define LCD3_CTRL_BYP2       5
`define LCD3_CTRL_BYP1       4
`define LCD3_CTRL_NOSYNC     3
`define LCD3_CTRL_FORCE      2
`define LCD3_CTRL_START2     1
`define LCD3_CTRL_START1     0
`define LCD3_CTRL_MASK       8'h3f

// duty correction register
`define LCD3_DCC_OFF_BIT     0
`define LCD3_DCC_MASK        8'h01

// status register bits
`define LCD3_ST_SYNC_HELD    0
`define LCD3_ST_FORCED       1
`define LCD3_ST_DIV1_OUT     2
`define LCD3_ST_DIV2_OUT     3
`define LCD3_ST_CH_OUT       4
`define LCD3_ST_SYNC_SEEN    5

`endif

// ==== lcd3_subdiv.v ====
// one low/high sub-divider with bypass, start level, phase offset and dcc
`timescale 1ns/1ps

module lcd3_subdiv (
    mclk,
    sys_rst,
    in_lvl,
    bypass,
    hold,
    start_high,
    phase,
    low_cnt,
    high_cnt,
    dcc_en,
    out_q
);
    input  wire       mclk;
    input  wire       sys_rst;
    input  wire       in_lvl;
    input  wire       bypass;
    input  wire       hold;
    input  wire       start_high;
    input  wire [3:0] phase;
    input  wire [3:0] low_cnt;
    input  wire [3:0] high_cnt;
    input  wire       dcc_en;
    output reg        out_q;

    // ======================================================================
    // input edges
    // ======================================================================
    reg        in_prev_q;
    reg  [4:0] cnt_q;
    reg        wait_fall_q;
    wire       in_rise;
    wire       in_fall;
    wire       half_en;
    wire [4:0] first_load;

    assign in_rise = in_lvl & ~in_prev_q;
    assign in_fall = ~in_lvl & in_prev_q;

    // odd period: stretch high by half a cycle, trim low by half
    assign half_en = dcc_en & (low_cnt[0] ^ high_cnt[0]);

    // first phase also carries the offset delay
    assign first_load = (start_high ? {1'b0, high_cnt} : {1'b0, low_cnt})
                      + {1'b0, phase};

    // ======================================================================
    // divider state
    // ======================================================================
    // counter holds cycles remaining minus one, so a zero field is one cycle
    always @(posedge mclk) begin
        if (sys_rst) begin
            in_prev_q   <= 1'b0;
            out_q       <= 1'b0;
            cnt_q       <= 5'h00;
            wait_fall_q <= 1'b0;
        end else begin
            in_prev_q <= in_lvl;
            if (bypass) begin
                // counter cleared to zero, clock passed through
                out_q       <= in_lvl;
                cnt_q       <= 5'h00;
                wait_fall_q <= 1'b0;
            end else if (hold) begin
                out_q       <= start_high;
                cnt_q       <= first_load;
                wait_fall_q <= 1'b0;
            end else if (wait_fall_q) begin
                if (in_fall) begin
                    out_q       <= 1'b0;
                    cnt_q       <= {1'b0, low_cnt};
                    wait_fall_q <= 1'b0;
                end
            end else if (in_rise) begin
                if (cnt_q == 5'h00) begin
                    if (out_q && half_en) begin
                        wait_fall_q <= 1'b1;
                    end else begin
                        out_q <= ~out_q;
                        cnt_q <= out_q ? {1'b0, low_cnt}
                                       : {1'b0, high_cnt};
                    end
                end else begin
                    cnt_q <= cnt_q - 5'h01;
                end
            end
        end
    end

endmodule

// ==== lcd3_checker.sv ====
// port assertions for the channel three divider pair
`timescale 1ns/1ps
`include "lcd3_regs.vh"

module lcd3_checker (
    input wire       mclk,
    input wire       sys_rst,
    input wire       tree_clk,
    input wire       sync_n,
    input wire [8:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata_q,
    input wire       div1_out_q,
    input wire       ch_out_q,
    input wire       sync_held_q
);
    reg  [7:0] ph_q, cn_q, ct_q, dc_q;
    wire       hold = !sync_n && ct_q[5:3] == 3'b000;

    // ======================================================================
    // shadow registers, updated on the same edge as the design's
    // ======================================================================
    always @(posedge mclk) begin
        if (sys_rst) begin
            ph_q <= 8'h00;
            cn_q <= 8'h00;
            ct_q <= 8'h00;
            dc_q <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == `LCD3_OFS_PHASE) ph_q <= reg_wdata;
            if (reg_addr == `LCD3_OFS_COUNTS2) cn_q <= reg_wdata;
            if (reg_addr == `LCD3_OFS_CTRL) ct_q <= reg_wdata & 8'h3f;
            if (reg_addr == `LCD3_OFS_DCC) dc_q <= reg_wdata & 8'h01;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_phase_rdback: assert property (reg_rd && reg_addr == 9'h19f
        |=> reg_rdata_q == ph_q) else $error("phase readback wrong");
    chk_count_rdback: assert property (reg_rd && reg_addr == 9'h1a0
        |=> reg_rdata_q == cn_q) else $error("count readback wrong");
    chk_ctrl_rdback: assert property (reg_rd && reg_addr == 9'h1a1
        |=> reg_rdata_q == ct_q) else $error("control readback wrong");
    chk_dcc_rdback: assert property (reg_rd && reg_addr == 9'h1a2
        |=> reg_rdata_q == dc_q) else $error("dcc readback wrong");
    chk_force_high: assert property ((ct_q[3] && ct_q[2])[*4]
        |-> ch_out_q) else $error("forced high not seen");
    chk_force_low: assert property ((ct_q[3] && !ct_q[2])[*4]
        |-> !ch_out_q) else $error("forced low not seen");
    chk_sync_ignored: assert property (ct_q[3] [*4]
        |-> !sync_held_q) else $error("sync honoured while ignored");
    chk_sync_obeyed: assert property ((!sync_n && !ct_q[3])[*4]
        |-> sync_held_q) else $error("sync not honoured");
    chk_start_one: assert property ((hold && $stable(ct_q))[*6]
        |-> div1_out_q == ct_q[0]) else $error("first start level wrong");
    chk_start_two: assert property ((hold && $stable(ct_q))[*6]
        |-> ch_out_q == ct_q[1]) else $error("second start level wrong");
    chk_bypass_one: assert property ((ct_q[4] && sync_n)[*4] ##0
        $rose(tree_clk) |-> ##[1:3] div1_out_q)
        else $error("bypass did not pass edge");

    cov_force_high: cover property (ct_q[3] && ct_q[2] && ch_out_q);
    cov_sync_held: cover property (sync_held_q && ct_q[1:0] == 2'b11);
    cov_bypass_one: cover property (ct_q[4] && $rose(div1_out_q));
endmodule

bind lcd3_top lcd3_checker chk_i (
    .mclk(mclk), .sys_rst(sys_rst), .tree_clk(tree_clk), .sync_n(sync_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .div1_out_q(div1_out_q),
    .ch_out_q(ch_out_q), .sync_held_q(sync_held_q));

// ==== lcd3_sink.sv ====
// downstream clock load that measures high and low lengths in mclk cycles
`timescale 1ns/1ps

module lcd3_sink (
    input wire        mclk,
    input wire        d1,
    input wire        ch,
    output reg [15:0] d1_hi,
    output reg [15:0] d1_lo,
    output reg [15:0] ch_hi,
    output reg [15:0] ch_lo
);
    reg [15:0] n1 = 16'h0001;
    reg [15:0] n2 = 16'h0001;
    reg        p1 = 1'b0;
    reg        p2 = 1'b0;

    // ======================================================================
    // segment meters; a length lands only when the segment has ended
    // ======================================================================
    always @(posedge mclk) begin
        p1 <= d1;
        p2 <= ch;
        n1 <= (d1 !== p1) ? 16'h0001 : n1 + 16'h0001;
        n2 <= (ch !== p2) ? 16'h0001 : n2 + 16'h0001;
        if (d1 !== p1 && p1) d1_hi <= n1;
        if (d1 !== p1 && !p1) d1_lo <= n1;
        if (ch !== p2 && p2) ch_hi <= n2;
        if (ch !== p2 && !p2) ch_lo <= n2;
    end
endmodule

// ==== test_lvds_cmos_channel_divider_three.sv ====
// self-checking bench for the channel three divider pair
`timescale 1ns/1ps
`include "lcd3_regs.vh"

module test_lvds_cmos_channel_divider_three;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [1:0]  tc = 2'b00;
    logic        sync_n = 1'b1;
    logic [3:0]  l1 = 4'h0, h1 = 4'h0, p;
    logic [8:0]  reg_addr = 9'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0, reg_rd = 1'b0;
    wire  [7:0]  reg_rdata_q;
    wire         div1_out_q, ch_out_q, sync_held_q;
    wire  [15:0] d1_hi, d1_lo, ch_hi, ch_lo;
    logic [31:0] seed = 32'ha3756aab;
    logic [15:0] v, u;
    integer      fails = 0, check_count = 0, i, d0, dp;

    lcd3_top DUT (.mclk(mclk), .sys_rst(sys_rst), .tree_clk(tc[1]),
        .sync_n(sync_n), .div1_low_cnt(l1), .div1_high_cnt(h1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .div1_out_q(div1_out_q), .ch_out_q(ch_out_q),
        .sync_held_q(sync_held_q));
    lcd3_sink sink (.mclk(mclk), .d1(div1_out_q), .ch(ch_out_q),
        .d1_hi(d1_hi), .d1_lo(d1_lo), .ch_hi(ch_hi), .ch_lo(ch_lo));

    // ======================================================================
    // clocks: tree clock is a quarter of mclk, one input cycle = 4 mclk
    // ======================================================================
    always #12.5 mclk = ~mclk;
    always @(posedge mclk) tc <= tc + 2'b01;

    function automatic [31:0] xs(input [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction
    // length of a field+1 segment in units
    function automatic [15:0] seg(input [3:0] n, input [15:0] un);
        seg = ({12'h000, n} + 16'h0001) * un;
    endfunction
    // full first-stage period in mclk cycles
    function automatic [15:0] per(input [3:0] l, input [3:0] h);
        per = 16'h0004 * ({12'h000, l} + {12'h000, h} + 16'h0002);
    endfunction

    task automatic check(input [15:0] seen, input [15:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // called just after an edge; one idle edge after the strobe keeps the
    // next call from raising the strobe in the step that lowers it
    task automatic wr(input [8:0] a, input [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input [8:0] a, input [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check({8'h00, reg_rdata_q}, {8'h00, e});
        @(posedge mclk);
    endtask
    // cycles from sync release, aligned to the tree clock, to first edge
    task automatic lag(input [3:0] ph, output integer d);
        wr(`LCD3_OFS_PHASE, {4'h0, ph});
        sync_n <= 1'b0;
        repeat (20) @(posedge mclk);
        repeat (4) if (tc != 2'b11) @(posedge mclk);
        sync_n <= 1'b1;
        d = 0;
        while (div1_out_q === 1'b0 && d < 400) begin
            @(posedge mclk);
            d = d + 1;
        end
        if (d >= 400) begin
            fails = fails + 1;
            give_verdict();
        end
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
            rd(`LCD3_OFS_PHASE + i[8:0], 8'h00);
            seed = xs(seed);
            wr(`LCD3_OFS_PHASE + i[8:0], seed[7:0]);
            u = {8'h00, (i == 2) ? 8'h3f : (i == 3) ? 8'h01 : 8'hff};
            rd(`LCD3_OFS_PHASE + i[8:0], seed[7:0] & u[7:0]);
        end
        rd(9'h100, 8'h00);
        wr(`LCD3_OFS_CTRL, 8'h00);
        wr(`LCD3_OFS_DCC, 8'h01);
        $display("registers done");
        // random divide ratios, then the largest fields as a corner
        for (i = 0; i < 4; i = i + 1) begin
            seed = xs(seed);
            v = (i == 3) ? 16'hffff : (seed[15:0] & 16'h7777);
            wr(`LCD3_OFS_COUNTS2, v[7:0]);
            l1 <= v[15:12];
            h1 <= v[11:8];
            u = per(v[15:12], v[11:8]);
            repeat (3 * u * ({12'h0, v[7:4]} + v[3:0] + 2) + 200)
                @(posedge mclk);
            check(d1_hi, seg(v[11:8], 16'h0004));
            check(d1_lo, seg(v[15:12], 16'h0004));
            check(ch_hi, seg(v[3:0], u));
            check(ch_lo, seg(v[7:4], u));
        end
        $display("divide ratios done");
        wr(`LCD3_OFS_COUNTS2, 8'h00);
        l1 <= 4'h1;
        h1 <= 4'h2;
        wr(`LCD3_OFS_DCC, 8'h00);
        repeat (300) @(posedge mclk);
        check(d1_hi, 16'd14);
        check(d1_lo, 16'd6);
        wr(`LCD3_OFS_DCC, 8'h01);
        repeat (300) @(posedge mclk);
        check(d1_hi, 16'd12);
        wr(`LCD3_OFS_CTRL, 8'h10);
        repeat (100) @(posedge mclk);
        check(d1_hi + d1_lo, 16'd4);
        wr(`LCD3_OFS_CTRL, 8'h20);
        repeat (200) @(posedge mclk);
        check(ch_hi, 16'd12);
        check(ch_lo, 16'd8);
        wr(`LCD3_OFS_CTRL, 8'h04);
        repeat (200) @(posedge mclk);
        check(ch_hi, per(4'h1, 4'h2));
        $display("duty and bypass done");
        for (i = 0; i < 2; i = i + 1) begin
            wr(`LCD3_OFS_CTRL, {5'h01, i[0], 2'b00});
            sync_n <= 1'b0;
            repeat (6) begin
                repeat (7) @(posedge mclk);
                check({15'h0, ch_out_q}, {15'h0, i[0]});
                check({15'h0, sync_held_q}, 16'h0000);
            end
            sync_n <= 1'b1;
        end
        for (i = 0; i < 4; i = i + 1) begin
            wr(`LCD3_OFS_CTRL, {6'h00, i[1:0]});
            sync_n <= 1'b0;
            repeat (20) @(posedge mclk);
            check({15'h0, div1_out_q}, {15'h0, i[0]});
            check({15'h0, ch_out_q}, {15'h0, i[1]});
            check({15'h0, sync_held_q}, 16'h0001);
            sync_n <= 1'b1;
        end
        $display("force and sync done");
        wr(`LCD3_OFS_CTRL, 8'h00);
        lag(4'h0, d0);
        for (i = 0; i < 2; i = i + 1) begin
            seed = xs(seed);
            p = (i == 0) ? 4'hf : seed[3:0] | 4'h1;
            lag(p, dp);
            check(dp - d0, {10'h000, p, 2'b00});
        end
        $display("phase offset done");
        give_verdict();
    end
endmodule
